// File: design/usi_pkg.sv
package usi_pkg;

	// ----------------------------------------
	// register map (word offsets, byte address)
	// ----------------------------------------
	localparam logic [7:0] ADDR_IER = 8'h00;
	localparam logic [7:0] ADDR_IDR = 8'h04;
	localparam logic [7:0] ADDR_IMR = 8'h08;
	localparam logic [7:0] ADDR_CSR = 8'h0c;
	localparam logic [7:0] ADDR_CTRL = 8'h10;
	localparam logic [7:0] ADDR_CMD = 8'h14;

	// ----------------------------------------
	// status bit positions
	// ----------------------------------------
	localparam int B_RX_CHAR_READY = 0;
	localparam int B_TX_HOLDING_FREE = 1;
	localparam int B_BRK = 2;
	localparam int B_RX_DMA_DONE = 3;
	localparam int B_TX_DMA_DONE = 4;
	localparam int B_OVR = 5;
	localparam int B_FRAME = 6;
	localparam int B_PAR = 7;
	localparam int B_TOUT = 8;
	localparam int B_TX_ALL_IDLE = 9;
	localparam int B_ITER = 10;
	localparam int B_TX_DMA_BUF_EMPTY = 11;
	localparam int B_RX_DMA_BUF_FULL = 12;
	localparam int B_NEG_ACK = 13;
	localparam int B_RIC = 16;
	localparam int B_DSRC = 17;
	localparam int B_DCDC = 18;
	localparam int B_CTSC = 19;
	localparam int B_MANC = 20;
	localparam int B_RI = 20;
	localparam int B_DSR = 21;
	localparam int B_DCD = 22;
	localparam int B_CTS = 23;
	localparam int B_MAN_ERR = 24;

	// mask bits 0..13 and 16..20 exist
	localparam logic [31:0] MASK_VALID = 32'h001f_3fff;
	localparam logic [31:0] MASK_RST = 32'h0000_0000;

	// ----------------------------------------
	// control / command bits
	// ----------------------------------------
	localparam int C_RXEN = 0;
	localparam int C_TXEN = 1;
	localparam int C_SINGLE_BIT = 2;
	localparam int K_CLEAR_STATUS = 0;
	localparam int K_CLEAR_REPEAT = 1;
	localparam int K_CLEAR_NEGACK = 2;
	localparam int K_START_TIMEOUT = 3;
	localparam int K_BEGIN_BREAK = 4;

	// events from the receiver / transmitter core
	typedef struct packed {
		logic rx_char;
		logic rhr_read;
		logic thr_load;
		logic thr_to_shift;
		logic shift_done;
		logic brk;
		logic ovr;
		logic frame;
		logic par;
		logic tout;
		logic iter;
		logic negative_ack_flag;
		logic man_err;
		logic brk_sent;
	} usi_evt_s;

	// dma levels
	typedef struct packed {
		logic rx_dma_done;
		logic tx_dma_done;
		logic tx_dma_buffer_empty;
		logic rx_dma_buffer_full;
	} usi_dma_s;

	// modem lines
	typedef struct packed {
		logic ri;
		logic dsr;
		logic dcd;
		logic cts;
	} usi_modem_s;

endpackage

// File: design/usi_status.sv
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/10ps
module usi_status (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	// register port
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	// core events and levels
	input wire usi_pkg::usi_evt_s evt_in,
	input wire usi_pkg::usi_dma_s dma_in,
	input wire logic [15:0] timeout_val_in,
	// modem pins (asynchronous)
	input wire usi_pkg::usi_modem_s modem_in,
	// outputs
	output logic rx_enable_out,
	output logic tx_enable_out,
	output logic single_bit_delimiter_out,
	output logic irq_out
);

	// ----------------------------------------
	// modem line synchronisers
	// ----------------------------------------
	logic [3:0] mod_s1_r, mod_s2_r, mod_s3_r;
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			mod_s1_r <= 4'h0;
			mod_s2_r <= 4'h0;
			mod_s3_r <= 4'h0;
		end else begin
			mod_s1_r <= modem_in;
			mod_s2_r <= mod_s1_r;
			mod_s3_r <= mod_s2_r;
		end
	end
	// order in vector: {ri,dsr,dcd,cts}
	// edges count only once the third stage holds a real pin sample
	logic [2:0] mod_primed_r;
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in)
			mod_primed_r <= 3'h0;
		else
			mod_primed_r <= {mod_primed_r[1:0], 1'b1};
	end

	// ----------------------------------------
	// decode
	// ----------------------------------------
	logic wr_ier, wr_idr, wr_ctrl, wr_cmd, rd_csr;
	logic cmd_clr_status, cmd_clr_repeat, cmd_clr_negack, cmd_start_tout, cmd_begin_break;
	always_comb begin
		wr_ier = reg_wr_in && reg_addr_in == usi_pkg::ADDR_IER;
		wr_idr = reg_wr_in && reg_addr_in == usi_pkg::ADDR_IDR;
		wr_ctrl = reg_wr_in && reg_addr_in == usi_pkg::ADDR_CTRL;
		wr_cmd = reg_wr_in && reg_addr_in == usi_pkg::ADDR_CMD;
		rd_csr = reg_rd_in && reg_addr_in == usi_pkg::ADDR_CSR;
		cmd_clr_status = wr_cmd && reg_wdata_in[usi_pkg::K_CLEAR_STATUS];
		cmd_clr_repeat = wr_cmd && reg_wdata_in[usi_pkg::K_CLEAR_REPEAT];
		cmd_clr_negack = wr_cmd && reg_wdata_in[usi_pkg::K_CLEAR_NEGACK];
		cmd_start_tout = wr_cmd && reg_wdata_in[usi_pkg::K_START_TIMEOUT];
		cmd_begin_break = wr_cmd && reg_wdata_in[usi_pkg::K_BEGIN_BREAK];
	end

	// ----------------------------------------
	// mask and control
	// ----------------------------------------
	logic [31:0] mask_r, mask_nxt;
	logic [2:0] ctrl_r, ctrl_nxt;
	always_comb begin
		mask_nxt = mask_r;
		if (wr_ier)
			mask_nxt = mask_nxt | (reg_wdata_in & usi_pkg::MASK_VALID);
		if (wr_idr)
			mask_nxt = mask_nxt & ~(reg_wdata_in & usi_pkg::MASK_VALID);
		ctrl_nxt = ctrl_r;
		if (wr_ctrl)
			ctrl_nxt = reg_wdata_in[2:0];
	end
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			mask_r <= usi_pkg::MASK_RST;
			ctrl_r <= 3'h0;
		end else begin
			mask_r <= mask_nxt;
			ctrl_r <= ctrl_nxt;
		end
	end

	// ----------------------------------------
	// flags
	// ----------------------------------------
	logic rx_pend_r, rx_pend_nxt;
	logic thr_full_r, thr_full_nxt;
	logic shift_busy_r, shift_busy_nxt;
	logic brk_req_r, brk_req_nxt;
	logic tout_arm_r, tout_arm_nxt;
	logic [12:0] sticky_r, sticky_nxt;
	// sticky: 0 brk 1 ovr 2 frame 3 par 4 tout 5 iter 6 negative_ack_flag
	// 7..10 cts,dcd,dsr,ri change 11 manchester_error_flag 12 unused
	logic [3:0] chg;
	always_comb begin
		chg = mod_primed_r[2] ? (mod_s2_r ^ mod_s3_r) : 4'h0;
		// pending char survives rx disable; shows on enable
		rx_pend_nxt = rx_pend_r;
		if (evt_in.rhr_read)
			rx_pend_nxt = 1'b0;
		if (evt_in.rx_char)
			rx_pend_nxt = 1'b1;
		thr_full_nxt = thr_full_r;
		if (evt_in.thr_to_shift)
			thr_full_nxt = 1'b0;
		if (evt_in.thr_load)
			thr_full_nxt = 1'b1;
		shift_busy_nxt = shift_busy_r;
		if (evt_in.shift_done)
			shift_busy_nxt = 1'b0;
		if (evt_in.thr_to_shift)
			shift_busy_nxt = 1'b1;
		brk_req_nxt = brk_req_r;
		if (evt_in.brk_sent)
			brk_req_nxt = 1'b0;
		if (cmd_begin_break)
			brk_req_nxt = 1'b1;
		tout_arm_nxt = tout_arm_r;
		if (evt_in.tout)
			tout_arm_nxt = 1'b0;
		if (cmd_start_tout)
			tout_arm_nxt = 1'b1;
		sticky_nxt = sticky_r;
		// status reset clears four, set wins; also clears manchester
		if (cmd_clr_status) begin
			sticky_nxt[3:0] = 4'h0;
			sticky_nxt[11] = 1'b0;
		end
		if (cmd_start_tout)
			sticky_nxt[4] = 1'b0;
		if (cmd_clr_repeat)
			sticky_nxt[5] = 1'b0;
		if (cmd_clr_negack)
			sticky_nxt[6] = 1'b0;
		if (rd_csr)
			sticky_nxt[10:7] = 4'h0;
		sticky_nxt[0] = sticky_nxt[0] | evt_in.brk;
		sticky_nxt[1] = sticky_nxt[1] | evt_in.ovr;
		sticky_nxt[2] = sticky_nxt[2] | evt_in.frame;
		sticky_nxt[3] = sticky_nxt[3] | evt_in.par;
		sticky_nxt[4] = sticky_nxt[4] |
			(evt_in.tout && tout_arm_r && timeout_val_in != 16'h0);
		sticky_nxt[5] = sticky_nxt[5] | evt_in.iter;
		sticky_nxt[6] = sticky_nxt[6] | evt_in.negative_ack_flag;
		sticky_nxt[10:7] = sticky_nxt[10:7] | chg;
		sticky_nxt[11] = sticky_nxt[11] | evt_in.man_err;
		sticky_nxt[12] = 1'b0;
		if (timeout_val_in == 16'h0)
			sticky_nxt[4] = 1'b0;
	end
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			rx_pend_r <= 1'b0;
			thr_full_r <= 1'b0;
			shift_busy_r <= 1'b0;
			brk_req_r <= 1'b0;
			tout_arm_r <= 1'b0;
			sticky_r <= 13'h0;
		end else begin
			rx_pend_r <= rx_pend_nxt;
			thr_full_r <= thr_full_nxt;
			shift_busy_r <= shift_busy_nxt;
			brk_req_r <= brk_req_nxt;
			tout_arm_r <= tout_arm_nxt;
			sticky_r <= sticky_nxt;
		end
	end

	// ----------------------------------------
	// status word
	// ----------------------------------------
	logic [31:0] csr;
	logic [20:0] src;
	logic rxen, txen;
	always_comb begin
		rxen = ctrl_r[usi_pkg::C_RXEN];
		txen = ctrl_r[usi_pkg::C_TXEN];
		csr = 32'h0;
		csr[usi_pkg::B_RX_CHAR_READY] = rx_pend_r && rxen;
		csr[usi_pkg::B_TX_HOLDING_FREE] = txen && !thr_full_r && !brk_req_r;
		csr[usi_pkg::B_BRK] = sticky_r[0];
		csr[usi_pkg::B_RX_DMA_DONE] = dma_in.rx_dma_done;
		csr[usi_pkg::B_TX_DMA_DONE] = dma_in.tx_dma_done;
		csr[usi_pkg::B_OVR] = sticky_r[1];
		csr[usi_pkg::B_FRAME] = sticky_r[2];
		csr[usi_pkg::B_PAR] = sticky_r[3];
		csr[usi_pkg::B_TOUT] = sticky_r[4];
		// empty only with both stages idle
		csr[usi_pkg::B_TX_ALL_IDLE] = txen && !thr_full_r && !shift_busy_r;
		csr[usi_pkg::B_ITER] = sticky_r[5];
		csr[usi_pkg::B_TX_DMA_BUF_EMPTY] = dma_in.tx_dma_buffer_empty;
		csr[usi_pkg::B_RX_DMA_BUF_FULL] = dma_in.rx_dma_buffer_full;
		csr[usi_pkg::B_NEG_ACK] = sticky_r[6];
		csr[usi_pkg::B_RIC] = sticky_r[10];
		csr[usi_pkg::B_DSRC] = sticky_r[9];
		csr[usi_pkg::B_DCDC] = sticky_r[8];
		csr[usi_pkg::B_CTSC] = sticky_r[7];
		csr[usi_pkg::B_RI] = mod_s2_r[3];
		csr[usi_pkg::B_DSR] = mod_s2_r[2];
		csr[usi_pkg::B_DCD] = mod_s2_r[1];
		csr[usi_pkg::B_CTS] = mod_s2_r[0];
		csr[usi_pkg::B_MAN_ERR] = sticky_r[11];
		// interrupt source view: manchester error sits at bit 20
		src = {sticky_r[11], csr[19:0]};
	end

	// ----------------------------------------
	// read data and outputs
	// ----------------------------------------
	logic [31:0] rdata_r, rdata_nxt;
	logic irq_r, irq_nxt;
	always_comb begin
		rdata_nxt = 32'h0;
		if (reg_rd_in) begin
			unique case (reg_addr_in)
				usi_pkg::ADDR_IMR: rdata_nxt = mask_r;
				usi_pkg::ADDR_CSR: rdata_nxt = csr;
				usi_pkg::ADDR_CTRL: rdata_nxt = {29'h0, ctrl_r};
				default: rdata_nxt = 32'h0;
			endcase
		end
		irq_nxt = |(src & mask_r[20:0]);
	end
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			rdata_r <= 32'h0;
			irq_r <= 1'b0;
		end else begin
			rdata_r <= rdata_nxt;
			irq_r <= irq_nxt;
		end
	end
	assign reg_rdata_out = rdata_r;
	assign irq_out = irq_r;
	assign rx_enable_out = ctrl_r[usi_pkg::C_RXEN];
	assign tx_enable_out = ctrl_r[usi_pkg::C_TXEN];
	assign single_bit_delimiter_out = ctrl_r[usi_pkg::C_SINGLE_BIT];

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_ier_sets;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		wr_ier |=> ((mask_r & $past(reg_wdata_in) & usi_pkg::MASK_VALID)
			== ($past(reg_wdata_in) & usi_pkg::MASK_VALID));
	endproperty
	a_ier_sets: assert property (p_ier_sets) else $error("enable write missed");
	property p_idr_clears;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		wr_idr |=> ((mask_r & $past(reg_wdata_in)) == 32'h0);
	endproperty
	a_idr_clears: assert property (p_idr_clears) else $error("disable write missed");
	property p_mask_keep;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		!wr_ier && !wr_idr |=> mask_r == $past(mask_r);
	endproperty
	a_mask_keep: assert property (p_mask_keep) else $error("mask changed");
	property p_imr_read;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		reg_rd_in && reg_addr_in == usi_pkg::ADDR_IMR |=> reg_rdata_out == $past(mask_r);
	endproperty
	a_imr_read: assert property (p_imr_read) else $error("mask view wrong");
	property p_status_clear;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		cmd_clr_status && !evt_in.par && !evt_in.ovr |=> !sticky_r[3] && !sticky_r[1];
	endproperty
	a_status_clear: assert property (p_status_clear) else $error("status reset failed");
	property p_ovr_sticky;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		evt_in.ovr |=> sticky_r[1];
	endproperty
	a_ovr_sticky: assert property (p_ovr_sticky) else $error("overrun lost");
	property p_chg_clear;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		rd_csr && chg == 4'h0 |=> sticky_r[10:7] == 4'h0;
	endproperty
	a_chg_clear: assert property (p_chg_clear) else $error("change flags stuck");
	property p_irq;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		|(src & mask_r[20:0]) |=> irq_out;
	endproperty
	a_irq: assert property (p_irq) else $error("irq missing");
	property p_tx_free;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		!txen |-> !csr[usi_pkg::B_TX_HOLDING_FREE] && !csr[usi_pkg::B_TX_ALL_IDLE];
	endproperty
	a_tx_free: assert property (p_tx_free) else $error("tx flags while disabled");
	property p_brk_sticky;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		evt_in.brk |=> csr[usi_pkg::B_BRK];
	endproperty
	a_brk_sticky: assert property (p_brk_sticky) else $error("break flag lost");
	property p_frame_hold;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		csr[usi_pkg::B_FRAME] && !cmd_clr_status |=> csr[usi_pkg::B_FRAME];
	endproperty
	a_frame_hold: assert property (p_frame_hold) else $error("framing flag dropped");
	property p_man_err;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		evt_in.man_err |=> csr[usi_pkg::B_MAN_ERR];
	endproperty
	a_man_err: assert property (p_man_err) else $error("manchester flag lost");
	property p_rx_off;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		!rxen |-> !csr[usi_pkg::B_RX_CHAR_READY];
	endproperty
	a_rx_off: assert property (p_rx_off) else $error("rx ready while disabled");
	property p_tout_zero;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		timeout_val_in == 16'h0 |=> !csr[usi_pkg::B_TOUT];
	endproperty
	a_tout_zero: assert property (p_tout_zero) else $error("timeout flag with zero value");
	property p_dma_mirror;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		csr[usi_pkg::B_RX_DMA_DONE] == dma_in.rx_dma_done
			&& csr[usi_pkg::B_TX_DMA_BUF_EMPTY] == dma_in.tx_dma_buffer_empty;
	endproperty
	a_dma_mirror: assert property (p_dma_mirror) else $error("dma level not mirrored");
	c_irq: cover property (@(posedge core_clk_in) disable iff (sys_rst_in) $rose(irq_out));
	c_tout: cover property (@(posedge core_clk_in) disable iff (sys_rst_in) $rose(sticky_r[4]));
	c_brk: cover property (@(posedge core_clk_in) disable iff (sys_rst_in) $rose(sticky_r[0]));
	c_mod: cover property (@(posedge core_clk_in) disable iff (sys_rst_in) |chg);

endmodule

// File: testbench/usi_far_end.sv
`timescale 1ns/10ps
// ----------------------------------------
// remote modem: line levels move only on command
// ----------------------------------------
module usi_far_end (
	// clock
	input wire logic clk_in,
	// lines to flip
	input wire logic [3:0] toggle_in,
	// modem pins toward the block
	output usi_pkg::usi_modem_s modem_out
);
	// levels start low, held until flipped
	usi_pkg::usi_modem_s lvl = '0;
	always @(posedge clk_in) begin
		lvl <= lvl ^ toggle_in;
	end
	assign modem_out = lvl;
endmodule

// File: testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
	logic clk, rst, wr, rd, rxe, txe, single_bit_delimiter, irq;
	logic [7:0] addr;
	logic [31:0] wdata, rdata;
	logic [15:0] tval;
	logic [3:0] tog;
	usi_pkg::usi_evt_s evt;
	usi_pkg::usi_dma_s dma;
	usi_pkg::usi_modem_s modem;
	int n_fail, samples_checked;
	usi_status uut (.core_clk_in(clk), .sys_rst_in(rst), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
		.evt_in(evt), .dma_in(dma), .timeout_val_in(tval), .modem_in(modem),
		.rx_enable_out(rxe), .tx_enable_out(txe), .single_bit_delimiter_out(single_bit_delimiter),
		.irq_out(irq));
	usi_far_end far (.clk_in(clk), .toggle_in(tog), .modem_out(modem));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s exp %h got %h", what, exp, got);
		end
	endtask
	task wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task rd_chk(input string what, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(what, exp, rdata & m);
	endtask
	task ev(input logic [13:0] v);
		@(posedge clk);
		evt <= v;
		@(posedge clk);
		evt <= '0;
	endtask
	task cmd(input logic [31:0] d);
		wr_reg(usi_pkg::ADDR_CMD, d);
	endtask
	task st(input string what, input logic [31:0] m, input logic [31:0] exp);
		rd_chk(what, usi_pkg::ADDR_CSR, m, exp);
	endtask
	task irq_chk(input logic exp);
		repeat (2) @(posedge clk);
		#1;
		chk("irq", {31'h0, exp}, {31'h0, irq});
	endtask
	task results;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// ----------------------------------------
	// clock, watchdog
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// tests need some 160 cycles; generous margin
	initial begin
		repeat (4000) @(posedge clk);
		n_fail++;
		results;
	end
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		rst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		tval = 16'h0;
		tog = 4'h0;
		evt = '0;
		dma = '0;
		n_fail = 0;
		samples_checked = 0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rd_chk("mask rst", usi_pkg::ADDR_IMR, 32'hffff_ffff, 32'h0);
		irq_chk(1'b0);
		done_msg("reset");
		wr_reg(usi_pkg::ADDR_IER, 32'hffff_ffff);
		rd_chk("mask all", usi_pkg::ADDR_IMR, 32'hffff_ffff, 32'h001f_3fff);
		wr_reg(usi_pkg::ADDR_IDR, 32'h0010_0005);
		rd_chk("mask part", usi_pkg::ADDR_IMR, 32'hffff_ffff, 32'h000f_3ffa);
		wr_reg(usi_pkg::ADDR_IER, 32'h0);
		wr_reg(usi_pkg::ADDR_IDR, 32'h0);
		rd_chk("mask zero", usi_pkg::ADDR_IMR, 32'hffff_ffff, 32'h000f_3ffa);
		wr_reg(usi_pkg::ADDR_IDR, 32'hffff_ffff);
		rd_chk("mask none", usi_pkg::ADDR_IMR, 32'hffff_ffff, 32'h0);
		rd_chk("unmapped", 8'h40, 32'hffff_ffff, 32'h0);
		done_msg("mask");
		// break, overrun, framing, parity, manchester, repeat, negative_ack_flag pulses
		ev(14'h01ee);
		st("errors", 32'h0100_24e4, 32'h0100_24e4);
		cmd(32'h1);
		st("clr sta", 32'h0100_24e4, 32'h0000_2400);
		cmd(32'h2);
		st("clr rep", 32'h0000_2400, 32'h0000_2000);
		cmd(32'h4);
		st("clr negative_ack_flag", 32'h0000_2400, 32'h0);
		done_msg("flags");
		st("tx off", 32'h202, 32'h0);
		wr_reg(usi_pkg::ADDR_CTRL, 32'h3);
		st("tx on", 32'h202, 32'h202);
		ev(14'h0800);
		st("thr full", 32'h202, 32'h0);
		ev(14'h0400);
		st("shifting", 32'h202, 32'h002);
		ev(14'h0200);
		st("idle", 32'h202, 32'h202);
		cmd(32'h10);
		st("brk req", 32'h2, 32'h0);
		ev(14'h0001);
		st("brk sent", 32'h2, 32'h2);
		done_msg("tx");
		ev(14'h2000);
		st("rx char", 32'h1, 32'h1);
		ev(14'h1000);
		st("rx read", 32'h1, 32'h0);
		wr_reg(usi_pkg::ADDR_CTRL, 32'h2);
		ev(14'h2000);
		st("rx off", 32'h1, 32'h0);
		wr_reg(usi_pkg::ADDR_CTRL, 32'h3);
		st("rx back", 32'h1, 32'h1);
		chk("en outs", 32'h3, {30'h0, txe, rxe});
		done_msg("rx");
		@(posedge clk);
		dma <= 4'b1010;
		st("dma a", 32'h1818, 32'h0808);
		@(posedge clk);
		dma <= 4'b0101;
		st("dma b", 32'h1818, 32'h1010);
		done_msg("dma");
		cmd(32'h8);
		ev(14'h0010);
		st("tout zero", 32'h100, 32'h0);
		@(posedge clk);
		tval <= 16'h0005;
		cmd(32'h8);
		ev(14'h0010);
		st("tout set", 32'h100, 32'h100);
		cmd(32'h8);
		st("tout rearm", 32'h100, 32'h0);
		done_msg("timeout");
		@(posedge clk);
		tog <= 4'hf;
		@(posedge clk);
		tog <= 4'h0;
		repeat (6) @(posedge clk);
		st("modem chg", 32'h00ff_0000, 32'h00ff_0000);
		st("modem clr", 32'h00ff_0000, 32'h00f0_0000);
		@(posedge clk);
		tog <= 4'h8;
		@(posedge clk);
		tog <= 4'h0;
		repeat (6) @(posedge clk);
		st("ring chg", 32'h00ff_0000, 32'h00e1_0000);
		done_msg("modem");
		wr_reg(usi_pkg::ADDR_IER, 32'h20);
		irq_chk(1'b0);
		ev(14'h0080);
		irq_chk(1'b1);
		cmd(32'h1);
		irq_chk(1'b0);
		done_msg("irq");
		wr_reg(usi_pkg::ADDR_CTRL, 32'h7);
		rd_chk("ctrl", usi_pkg::ADDR_CTRL, 32'h7, 32'h7);
		chk("one bit", 32'h1, {31'h0, single_bit_delimiter});
		wr_reg(usi_pkg::ADDR_CTRL, 32'h3);
		#1;
		chk("sync sfd", 32'h0, {31'h0, single_bit_delimiter});
		done_msg("delimiter");
		results;
	end
	task done_msg(input string t);
		$display("test %s done", t);
	endtask
endmodule
